/* logic/misp_dev.sv */
/*
 Two-wire slave port of the monitor: shadow RAM, nonvolatile array,
 access select register, page writes, reads, page recall, watchdog.
 Assumes a master on the link no faster than 400 kHz and a 25 MHz clk.
*/
// Implementation choice: the two-wire slave port; AXI4-Lite sits on the host side.
// Functional notes
// - Separate data in and out pins
// - Link clock at most 400 kHz
// - Address-select pin picks slave address
// - Slave only, MSB first
// - Data changes only while clock low
// - Ignore everything until a start
// - Stop returns port to idle
// - Ack matching slave byte and later bytes
// - Read: send, sample ack, continue or cease
// - Stop after a nonvolatile write starts busy write cycle
// - No ack for writes to protected area
// - Page write wraps within four bytes
// - Master avoids reserved addresses; the host refuses only writes there, reads pass
// - Read bit set selects read
// - Address counter is last address plus one
// - Master ends read by nack, stop
// - Random read: dummy write, restart, read
// - Sequential read wraps whole space
// - Nonvolatile page start triggers slow recall
// - Master retries reads until acknowledged, at most 64 times
// - Select register routes RAM or nonvolatile
// - Watchdog clears select when traffic stops
// - Power-up copies configuration into shadow
`timescale 1ns/1ps
`default_nettype none
`include "misp_regs.svh"
module misp_dev
    import misp_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR0 = `MISP_DEV_ADDR0,
    parameter logic [6:0] DEV_ADDR1 = `MISP_DEV_ADDR1,
    parameter int WRITE_CYC = `MISP_WRITE_US * `MISP_CLK_MHZ,
    parameter int RECALL_CYC = `MISP_RECALL_US * `MISP_CLK_MHZ + 1,
    parameter int WDOG_CYC = `MISP_WDOG_US * `MISP_CLK_MHZ
) (
    input wire logic clk,
    input wire logic resetn,
    misp_link_if.dev link,
    input wire logic addr_sel,
    output logic nvm_select_bit,
    output logic port_busy
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and condition detection

logic [1:0] scl_sync_q, sda_sync_q, asel_sync_q;
logic scl_prev_q, sda_prev_q;
logic scl_s, sda_s, scl_rise, scl_fall, start_cond, stop_cond;

always_ff @(posedge clk) begin
    if (!resetn) begin
        scl_sync_q <= 2'h3;
        sda_sync_q <= 2'h3;
        asel_sync_q <= 2'h0;
        scl_prev_q <= 1'b1;
        sda_prev_q <= 1'b1;
    end else begin
        scl_sync_q <= {scl_sync_q[0], link.scl};
        sda_sync_q <= {sda_sync_q[0], link.serial_data_in};
        asel_sync_q <= {asel_sync_q[0], addr_sel};
        scl_prev_q <= scl_s;
        sda_prev_q <= sda_s;
    end
end

assign scl_s = scl_sync_q[1];
assign sda_s = sda_sync_q[1];
// The link clock's edges, a start and a stop move the port; it never drives the clock
assign scl_rise = scl_s && !scl_prev_q;
assign scl_fall = !scl_s && scl_prev_q;
// Data moving under a high clock is only ever a start or a stop
assign start_cond = scl_s && scl_prev_q && sda_prev_q && !sda_s;
assign stop_cond = scl_s && scl_prev_q && !sda_prev_q && sda_s;

////////////////////////////////////////////////////////////////////////////////
// Storage and decode

logic [7:0] ram [0:255];
logic [7:0] nvm [0:127];
misp_dev_state_t state_q;
misp_rx_kind_t kind_q;
logic [2:0] cnt_q;
logic [7:0] sh_q, tx_q, addr_q;
logic ack_q, drv_q, oe_q, rw_q, wnvm_q, sel_q;
logic booting_q, recall_ok_q;
logic [6:0] boot_idx_q;
logic [16:0] busy_q;
logic [12:0] recall_q;
logic [5:0] recall_pg_q;
logic [24:0] wdog_q;
logic [7:0] byte_in, rd_byte;
logic [6:0] own_addr;
logic byte_done, addr_is_nvm, prot, wr_fire, need_recall, dev_match, blocked;

assign byte_in = {sh_q[6:0], sda_s};
assign byte_done = state_q == S_RX && scl_rise && cnt_q == 3'h7;
assign own_addr = asel_sync_q[1] ? DEV_ADDR1 : DEV_ADDR0;
assign addr_is_nvm = sel_q && !addr_q[7];
// Measured values and the space above them do not take writes
assign prot = !addr_is_nvm && addr_q >= `MISP_RO_LO;
assign wr_fire = byte_done && kind_q == K_DATA && !prot;
assign need_recall = addr_is_nvm && addr_q[1:0] == 2'h0
    && !(recall_ok_q && recall_pg_q == addr_q[7:2]);
assign dev_match = byte_in[7:1] == own_addr;
// Busy write cycle or power-up copy: bus requests are not seen at all
assign blocked = booting_q || busy_q != 17'h0;
assign rd_byte = addr_q == `MISP_SEL_ADDR ? {7'h0, sel_q}
    : addr_is_nvm ? nvm[addr_q[6:0]] : ram[addr_q];

always_ff @(posedge clk) begin
    if (booting_q) begin
        ram[{1'b0, boot_idx_q}] <= nvm[boot_idx_q];
    end else if (wr_fire) begin
        if (addr_is_nvm) begin
            nvm[addr_q[6:0]] <= byte_in;
        end else begin
            ram[addr_q] <= byte_in;
        end
    end
end

// The user area above the shadow end has no RAM copy
always_ff @(posedge clk) begin
    if (!resetn) begin
        booting_q <= 1'b1;
        boot_idx_q <= 7'h0;
    end else if (booting_q) begin
        boot_idx_q <= boot_idx_q + 7'h1;
        booting_q <= boot_idx_q != `MISP_SHADOW_END;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Bit engine

always_ff @(posedge clk) begin
    if (!resetn) begin
        state_q <= S_IDLE;
        kind_q <= K_DEV;
        cnt_q <= 3'h0;
        sh_q <= 8'h00;
        tx_q <= 8'h00;
        addr_q <= 8'h00;
        ack_q <= 1'b0;
        drv_q <= 1'b0;
        oe_q <= 1'b0;
        rw_q <= 1'b0;
        wnvm_q <= 1'b0;
    end else if (blocked || stop_cond) begin
        state_q <= S_IDLE;
        oe_q <= 1'b0;
        wnvm_q <= 1'b0;
    end else if (start_cond) begin
        state_q <= S_RX;
        kind_q <= K_DEV;
        cnt_q <= 3'h0;
        oe_q <= 1'b0;
    end else begin
        unique case (state_q)
            S_IDLE: begin
                oe_q <= 1'b0;
            end
            S_RX: begin
                if (scl_rise) begin
                    sh_q <= byte_in;
                    cnt_q <= cnt_q + 3'h1;
                end
                if (byte_done) begin
                    state_q <= S_RXACK;
                    drv_q <= 1'b0;
                    unique case (kind_q)
                        K_DEV: begin
                            // Read bit set means read; nack a read while a recall is needed or runs
                            ack_q <= dev_match && !(byte_in[0]
                                && (need_recall || recall_q != 13'h0));
                            rw_q <= byte_in[0];
                        end
                        K_WORD: begin
                            ack_q <= 1'b1;
                            addr_q <= byte_in;
                        end
                        K_DATA: begin
                            ack_q <= !prot;
                            if (!prot) begin
                                addr_q <= {addr_q[7:2], addr_q[1:0] + 2'h1};
                                wnvm_q <= wnvm_q || addr_is_nvm;
                            end
                        end
                    endcase
                end
            end
            S_RXACK: begin
                if (scl_fall && !drv_q) begin
                    oe_q <= ack_q;
                    drv_q <= 1'b1;
                end else if (scl_fall) begin
                    oe_q <= 1'b0;
                    cnt_q <= 3'h0;
                    if (!ack_q) begin
                        state_q <= S_IDLE;
                    end else if (kind_q == K_DEV && rw_q) begin
                        tx_q <= rd_byte;
                        oe_q <= !rd_byte[7];
                        state_q <= S_TX;
                    end else begin
                        kind_q <= kind_q == K_DEV ? K_WORD : K_DATA;
                        state_q <= S_RX;
                    end
                end
            end
            S_TX: begin
                if (scl_fall && cnt_q == 3'h7) begin
                    oe_q <= 1'b0;
                    state_q <= S_TXACK;
                end else if (scl_fall) begin
                    tx_q <= {tx_q[6:0], 1'b0};
                    oe_q <= !tx_q[6];
                    cnt_q <= cnt_q + 3'h1;
                end
            end
            S_TXACK: begin
                if (scl_rise) begin
                    ack_q <= !sda_s;
                    addr_q <= addr_q + 8'h01;
                end else if (scl_fall && ack_q) begin
                    tx_q <= rd_byte;
                    oe_q <= !rd_byte[7];
                    cnt_q <= 3'h0;
                    state_q <= S_TX;
                end else if (scl_fall) begin
                    state_q <= S_IDLE;
                end
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Write cycle, page recall, select register and watchdog

always_ff @(posedge clk) begin
    if (!resetn) begin
        busy_q <= 17'h0;
    end else if (stop_cond && wnvm_q && !blocked) begin
        busy_q <= 17'(WRITE_CYC);
    end else if (busy_q != 17'h0) begin
        busy_q <= busy_q - 17'h1;
    end
end

// A later sequential read crossing a page start is served without a recall
always_ff @(posedge clk) begin
    if (!resetn) begin
        recall_q <= 13'h0;
        recall_ok_q <= 1'b0;
        recall_pg_q <= 6'h0;
    end else if (byte_done && kind_q == K_DEV && dev_match && byte_in[0]
            && need_recall && recall_q == 13'h0) begin
        recall_q <= 13'(RECALL_CYC);
        recall_pg_q <= addr_q[7:2];
        recall_ok_q <= 1'b0;
    end else if (recall_q != 13'h0) begin
        recall_q <= recall_q - 13'h1;
        recall_ok_q <= recall_q == 13'h1;
    end else if (!sel_q) begin
        recall_ok_q <= 1'b0;
    end
end

// A write to the select register wins over the watchdog clearing it
always_ff @(posedge clk) begin
    if (!resetn) begin
        sel_q <= `MISP_SEL_RST;
    end else if (wr_fire && addr_q == `MISP_SEL_ADDR) begin
        sel_q <= byte_in[`MISP_SEL_BIT];
    end else if (wdog_q == 25'(WDOG_CYC - 1)) begin
        sel_q <= 1'b0;
    end
end

always_ff @(posedge clk) begin
    if (!resetn || scl_rise || scl_fall || !sel_q) begin
        wdog_q <= 25'h0;
    end else if (wdog_q != 25'(WDOG_CYC - 1)) begin
        wdog_q <= wdog_q + 25'h1;
    end
end

always_ff @(posedge clk) begin
    if (!resetn) begin
        port_busy <= 1'b1;
        nvm_select_bit <= `MISP_SEL_RST;
    end else begin
        port_busy <= blocked;
        nvm_select_bit <= sel_q;
    end
end

// Open drain: output level is always low, the enable pulls the line
assign link.serial_data_out = 1'b0;
assign link.serial_data_out_oe = oe_q;

endmodule // misp_dev
`default_nettype wire

/* logic/misp_host.sv */
/*
 Two-wire bus master for the slave port, commanded over AXI4-Lite:
 byte write, random read and current-address read.
 Assumes a 25 MHz clk; it makes the link clock itself by a divider.
*/
`timescale 1ns/1ps
`default_nettype none
`include "misp_regs.svh"
module misp_host
    import misp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    misp_link_if.host link,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);

////////////////////////////////////////////////////////////////////////////////
// Register slave

logic aw_got_q, w_got_q, busy_q, nack_q, go;
logic [7:0] awaddr_q, rdata_q, dev_q, word_q, wdat_q;
logic [31:0] wdata_q;
logic [3:0] wstrb_q;
misp_op_t op_q;
logic cmd_ok;

// Writes into the reserved holes are refused before reaching the link
assign cmd_ok = awaddr_q == `MISP_REG_CMD && wstrb_q == 4'hf && !busy_q
    && (wdata_q[`MISP_CMD_RD_BIT] || wdata_q[`MISP_CMD_CUR_BIT]
    || !((wdata_q[`MISP_CMD_WORD_LSB +: 8] >= `MISP_RESV_LO
    && wdata_q[`MISP_CMD_WORD_LSB +: 8] <= `MISP_RESV_HI)
    || wdata_q[`MISP_CMD_WORD_LSB +: 8] > `MISP_TOP_ADDR));
assign go = aw_got_q && w_got_q && !s_axi_bvalid && cmd_ok;

always_ff @(posedge clk) begin
    if (!resetn) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `MISP_RESP_OKAY;
        awaddr_q <= 8'h00;
        wdata_q <= 32'h0;
        wstrb_q <= 4'h0;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_got_q && !s_axi_bvalid;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_got_q && !s_axi_bvalid;
        end
        if (aw_got_q && w_got_q && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= cmd_ok ? `MISP_RESP_OKAY : `MISP_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
        end
    end
end

always_ff @(posedge clk) begin
    if (!resetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `MISP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= s_axi_araddr == `MISP_REG_STAT ? `MISP_RESP_OKAY : `MISP_RESP_SLVERR;
        s_axi_rdata <= s_axi_araddr != `MISP_REG_STAT ? 32'h0
            : {16'h0, rdata_q, 6'h0, nack_q, busy_q};
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end else begin
        s_axi_arready <= !s_axi_rvalid;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Link sequencer

logic [1:0] sda_sync_q, qtr_q;
logic [4:0] tick_q;
logic [2:0] step_q, stop_step;
logic [3:0] bit_q;
logic [7:0] retry_q, tx_byte;
logic scl_q, sda_oe_q, tick, lvl_scl, lvl_sda;
misp_sym_t sym;

always_comb begin
    sym = Y_TX;
    tx_byte = {dev_q[6:0], 1'b0};
    stop_step = 3'h4;
    unique case (op_q)
        OP_WRITE: begin
            sym = step_q == 3'h0 ? Y_START : step_q == 3'h4 ? Y_STOP : Y_TX;
            tx_byte = step_q == 3'h2 ? word_q : step_q == 3'h3 ? wdat_q : tx_byte;
        end
        OP_RAND: begin
            // Dummy write of the word address, then a restart and a read
            sym = step_q == 3'h0 || step_q == 3'h3 ? Y_START
                : step_q == 3'h5 ? Y_RX : step_q == 3'h6 ? Y_STOP : Y_TX;
            tx_byte = step_q == 3'h2 ? word_q : step_q == 3'h4 ? {dev_q[6:0], 1'b1} : tx_byte;
            stop_step = 3'h6;
        end
        OP_CUR: begin
            sym = step_q == 3'h0 ? Y_START : step_q == 3'h2 ? Y_RX : step_q == 3'h3 ? Y_STOP : Y_TX;
            tx_byte = {dev_q[6:0], 1'b1};
            stop_step = 3'h3;
        end
    endcase
    // Data bits set in quarter 0 with the clock low; start and stop move data in quarter 2
    lvl_scl = qtr_q == 2'h1 || qtr_q == 2'h2;
    lvl_sda = 1'b1;
    unique case (sym)
        Y_START: lvl_sda = qtr_q[1] == 1'b0;
        Y_STOP: begin
            lvl_scl = qtr_q != 2'h0;
            lvl_sda = qtr_q[1];
        end
        Y_TX: lvl_sda = bit_q == 4'h8 || tx_byte[3'(4'h7 - bit_q)];
        Y_RX: lvl_sda = 1'b1;
    endcase
end

assign tick = tick_q == 5'(`MISP_QTR_CYC - 1);

always_ff @(posedge clk) begin
    if (!resetn) begin
        sda_sync_q <= 2'h3;
        tick_q <= 5'h0;
    end else begin
        sda_sync_q <= {sda_sync_q[0], link.serial_data_in};
        tick_q <= tick || !busy_q ? 5'h0 : tick_q + 5'h1;
    end
end

always_ff @(posedge clk) begin
    if (!resetn) begin
        busy_q <= 1'b0;
        nack_q <= 1'b0;
        op_q <= OP_WRITE;
        dev_q <= 8'h00;
        word_q <= 8'h00;
        wdat_q <= 8'h00;
        rdata_q <= 8'h00;
        retry_q <= 8'h00;
        step_q <= 3'h0;
        bit_q <= 4'h0;
        qtr_q <= 2'h0;
        scl_q <= 1'b1;
        sda_oe_q <= 1'b0;
    end else if (go) begin
        busy_q <= 1'b1;
        nack_q <= 1'b0;
        op_q <= wdata_q[`MISP_CMD_CUR_BIT] ? OP_CUR
            : wdata_q[`MISP_CMD_RD_BIT] ? OP_RAND : OP_WRITE;
        dev_q <= {1'b0, wdata_q[`MISP_CMD_DEV_LSB +: 7]};
        word_q <= wdata_q[`MISP_CMD_WORD_LSB +: 8];
        wdat_q <= wdata_q[7:0];
        retry_q <= `MISP_RETRY_MAX;
        step_q <= 3'h0;
        bit_q <= 4'h0;
        qtr_q <= 2'h0;
    end else if (busy_q && tick) begin
        scl_q <= lvl_scl;
        sda_oe_q <= !lvl_sda;
        qtr_q <= qtr_q + 2'h1;
        if (qtr_q == 2'h3) begin
            if (sym == Y_RX && bit_q != 4'h8) begin
                rdata_q <= {rdata_q[6:0], sda_sync_q[1]};
            end
            if (sym == Y_STOP) begin
                // A nacked slave byte of a read restarts the whole sequence while retries remain
                busy_q <= nack_q && op_q != OP_WRITE && retry_q != 8'h00;
                nack_q <= nack_q && !(op_q != OP_WRITE && retry_q != 8'h00);
                retry_q <= retry_q - 8'h01;
                step_q <= 3'h0;
            end else if ((sym == Y_TX || sym == Y_RX) && bit_q != 4'h8) begin
                bit_q <= bit_q + 4'h1;
            end else if (sym == Y_TX && sda_sync_q[1]) begin
                nack_q <= 1'b1;
                bit_q <= 4'h0;
                step_q <= stop_step;
            end else begin
                bit_q <= 4'h0;
                step_q <= step_q + 3'h1;
            end
        end
    end
end

assign link.scl = scl_q;
assign link.host_sda_oe = sda_oe_q;

endmodule // misp_host
`default_nettype wire

/* logic/misp_link_if.sv */
/*
 The two-wire link between controller and slave port.
 Resolves the open-drain data line with a pull-up; the clock is driven
 by the controller alone.
*/
`timescale 1ns/1ps
`default_nettype none
interface misp_link_if;
    logic scl;
    logic host_sda_oe;
    logic serial_data_out;
    logic serial_data_out_oe;
    logic serial_data_in;
    // Data input and output pins tied together, pulled high when released
    assign serial_data_in = !(host_sda_oe || (serial_data_out_oe && !serial_data_out));
    modport dev (input scl, input serial_data_in, output serial_data_out,
        output serial_data_out_oe);
    modport host (output scl, output host_sda_oe, input serial_data_in);
endinterface
`default_nettype wire

/* logic/misp_pkg.sv */
/*
 Types shared by both ends of the two-wire slave port.
 Assumes nothing of its surroundings.
*/
package misp_pkg;
    typedef enum logic [2:0] {S_IDLE, S_RX, S_RXACK, S_TX, S_TXACK} misp_dev_state_t;
    typedef enum logic [1:0] {K_DEV, K_WORD, K_DATA} misp_rx_kind_t;
    typedef enum logic [1:0] {Y_START, Y_TX, Y_RX, Y_STOP} misp_sym_t;
    typedef enum logic [1:0] {OP_WRITE, OP_RAND, OP_CUR} misp_op_t;
endpackage

/* logic/misp_regs.svh */
/*
 Constants of the two-wire slave port and of its controller: offsets,
 field positions, reset values and timing figures.
 Assumes a 25 MHz system clock on both ends.
*/
`ifndef MISP_REGS_SVH
`define MISP_REGS_SVH
`define MISP_CLK_KHZ 25000
`define MISP_CLK_MHZ 25
`define MISP_SCL_KHZ 400
`define MISP_QTR_CYC ((`MISP_CLK_KHZ + 4 * `MISP_SCL_KHZ - 1) / (4 * `MISP_SCL_KHZ))
`define MISP_RECALL_US 200
`define MISP_WRITE_US 5000
`define MISP_WDOG_US 1000000
`define MISP_DEV_ADDR0 7'h28
`define MISP_DEV_ADDR1 7'h29
`define MISP_SEL_ADDR 8'h89
`define MISP_SEL_BIT 0
`define MISP_SEL_RST 1'b0
`define MISP_SHADOW_END 7'h4f
`define MISP_RO_LO 8'h8a
`define MISP_RESV_LO 8'h58
`define MISP_RESV_HI 8'h7f
`define MISP_TOP_ADDR 8'hab
`define MISP_REG_CMD 8'h00
`define MISP_REG_STAT 8'h04
`define MISP_CMD_WORD_LSB 8
`define MISP_CMD_DEV_LSB 16
`define MISP_CMD_RD_BIT 24
`define MISP_CMD_CUR_BIT 25
`define MISP_STAT_NACK_BIT 1
`define MISP_STAT_DATA_LSB 8
`define MISP_RETRY_MAX 8'h40
`define MISP_RESP_OKAY 2'h0
`define MISP_RESP_SLVERR 2'h2
`endif

/* testbench/misp_link_properties.sv */
/*
 Checks on the two-wire link between host and slave port.
 Assumes clk samples the link; resetn is synchronous, active low.
*/
`timescale 1ns/1ps
`default_nettype none
module misp_link_properties (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic host_sda_oe,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe,
    input wire logic serial_data_in
);
    logic seen_q;
    always_ff @(posedge clk) begin
        if (!resetn) seen_q <= 1'b0;
        else if (scl && $fell(serial_data_in)) seen_q <= 1'b1;
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence start_seen; scl && $fell(serial_data_in); endsequence
    sequence stop_seen; scl && $rose(serial_data_in); endsequence
    // Synchroniser lag: the port moves a few clk after scl falls
    sequence fell_lately; !scl && !$past(scl, 2) && $past(scl, 6); endsequence
    chk_out_low: assert property (serial_data_out == 1'b0)
        else $error("data output not low");
    chk_line_pulled: assert property (serial_data_out_oe |-> !serial_data_in)
        else $error("line not pulled low");
    chk_change_low: assert property ($changed(serial_data_out_oe) |-> !scl)
        else $error("drive moved with scl high");
    chk_answer_lag: assert property ($changed(serial_data_out_oe) |-> fell_lately)
        else $error("drive moved off time");
    chk_drive_holds: assert property ($rose(serial_data_out_oe) |=> serial_data_out_oe[*8])
        else $error("ack dropped early");
    chk_quiet_idle: assert property (!seen_q |-> !serial_data_out_oe)
        else $error("drive before start");
    chk_start_quiet: assert property (start_seen |-> (!serial_data_out_oe)[*8])
        else $error("drive after start");
    chk_stop_release: assert property (stop_seen |=> (!serial_data_out_oe)[*8])
        else $error("drive after stop");
endmodule // misp_link_properties
`default_nettype wire

/* testbench/tb_top.sv */
/*
 Bench: host and slave port joined by the link, driven over AXI4-Lite.
 Assumes shortened write, recall and watchdog counts in the port.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk;
    logic resetn = 1'b0, addr_sel = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic nvm_select_bit, port_busy;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int error_cnt = 0;
    int tests_run = 0;
    misp_link_if misp_link_if_inst ();
    misp_dev #(.WRITE_CYC(200), .RECALL_CYC(50), .WDOG_CYC(500)) misp_dev_inst (.clk,
        .resetn, .link(misp_link_if_inst), .addr_sel, .nvm_select_bit, .port_busy);
    misp_host misp_host_inst (.clk, .resetn, .link(misp_link_if_inst), .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp);
    misp_link_properties misp_link_properties_inst (.clk, .resetn,
        .scl(misp_link_if_inst.scl), .host_sda_oe(misp_link_if_inst.host_sda_oe),
        .serial_data_out(misp_link_if_inst.serial_data_out),
        .serial_data_out_oe(misp_link_if_inst.serial_data_out_oe),
        .serial_data_in(misp_link_if_inst.serial_data_in));
    ////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axi_wr(input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= 8'h00;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // op: 0 byte write, 1 random read, 2 current-address read; waits till host idle
    task automatic run(input logic [1:0] op, input logic [6:0] sa, input logic [7:0] wa,
        input logic [7:0] dat, input logic nack, input logic [7:0] exp);
        logic [1:0] r;
        logic [31:0] st;
        axi_wr({6'h00, op, 1'b0, sa, wa, dat}, r);
        check("bresp", 32'h0, {30'h0, r});
        do axi_rd(8'h04, st, r); while (st[0] !== 1'b0);
        check("nack", {31'h0, nack}, {31'h0, st[1]});
        if (op != 2'b00) check("data", {24'h0, exp}, {24'h0, st[15:8]});
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        end_sim;
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        do @(posedge clk); while (port_busy !== 1'b0);
        run(2'b00, 7'h28, 8'h10, 8'ha5, 1'b0, 8'h00);
        run(2'b00, 7'h28, 8'h11, 8'h3c, 1'b0, 8'h00);
        run(2'b01, 7'h28, 8'h10, 8'h00, 1'b0, 8'ha5);
        run(2'b10, 7'h28, 8'h00, 8'h00, 1'b0, 8'h3c);
        run(2'b00, 7'h29, 8'h12, 8'h77, 1'b1, 8'h00);
        addr_sel <= 1'b1;
        repeat (4) @(posedge clk);
        run(2'b01, 7'h29, 8'h10, 8'h00, 1'b0, 8'ha5);
        addr_sel <= 1'b0;
        repeat (4) @(posedge clk);
        run(2'b00, 7'h28, 8'h8a, 8'h01, 1'b1, 8'h00);
        axi_wr({16'h0028, 8'h60, 8'h01}, r);
        check("reserved", 32'h2, {30'h0, r});
        axi_rd(8'h08, d, r);
        check("unmapped", 32'h2, {30'h0, r});
        run(2'b00, 7'h28, 8'h89, 8'h01, 1'b0, 8'h00);
        check("select", 32'h1, {31'h0, nvm_select_bit});
        run(2'b01, 7'h28, 8'h89, 8'h00, 1'b0, 8'h01);
        run(2'b00, 7'h28, 8'h20, 8'h5a, 1'b0, 8'h00);
        check("busy", 32'h1, {31'h0, port_busy});
        do @(posedge clk); while (port_busy !== 1'b0);
        run(2'b01, 7'h28, 8'h20, 8'h00, 1'b0, 8'h5a);
        repeat (600) @(posedge clk);
        check("select", 32'h0, {31'h0, nvm_select_bit});
        run(2'b01, 7'h28, 8'h10, 8'h00, 1'b0, 8'ha5);
        // Write at a page's last byte leaves the counter on the page's first byte
        run(2'b00, 7'h28, 8'h13, 8'hc3, 1'b0, 8'h00);
        run(2'b10, 7'h28, 8'h00, 8'h00, 1'b0, 8'ha5);
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
